// File: src/dq_odt_consts.vh
`ifndef DQ_ODT_CONSTS_VH
`define DQ_ODT_CONSTS_VH

// ****************************************************************
// Lane counts and bus geometry
// ****************************************************************
`define DQ_WIDTH        16
`define APB_ADDR_W      12

// ****************************************************************
// Register offsets, field positions and reset values
// ****************************************************************
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define CTRL_SET_MSB    2
`define CTRL_SET_LSB    0
`define CTRL_WRITE_LATENCY_SET_B   3
`define CTRL_BAND_MSB   6
`define CTRL_BAND_LSB   4
`define CTRL_BL32       7
`define CTRL_WR_LEVEL   8
`define CTRL_RESET      32'h0000_0000
`define TERM_CODE_OFF   3'h0

// ****************************************************************
// Latency tables in command clock cycles, per frequency band
// ****************************************************************
`define ON_A_B3         6'h04
`define ON_A_B5         6'h06
`define ON_A_B7         6'h08
`define OFF_A_B3        6'h14
`define OFF_A_B4        6'h16
`define OFF_A_B5        6'h18
`define OFF_A_B6        6'h1a
`define OFF_A_B7        6'h1c
`define ON_B_B2         6'h06
`define ON_B_B3         6'h0c
`define ON_B_B4         6'h0e
`define ON_B_B5         6'h12
`define ON_B_B6         6'h14
`define ON_B_B7         6'h18
`define OFF_B_B2        6'h16
`define OFF_B_B3        6'h1c
`define OFF_B_B4        6'h20
`define OFF_B_B5        6'h24
`define OFF_B_B6        6'h28
`define OFF_B_B7        6'h2c
`define BL32_EXTRA_CYC  6'h08

// ****************************************************************
// Switch windows, in picoseconds and in pclk cycles
// ****************************************************************
`define CLK_PERIOD_PS   8000
`define WIN_MIN_PS      1500
`define WIN_MAX_PS      3500
`define WIN_MIN_CYC     ((`WIN_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WIN_MAX_RAW     (`WIN_MAX_PS / `CLK_PERIOD_PS)
`define WIN_MAX_CYC     ((`WIN_MAX_RAW < 1) ? 1 : `WIN_MAX_RAW)

`endif

// File: src/term_latency_lookup.v
`timescale 1ns/1ps
`default_nettype none
`include "dq_odt_consts.vh"

// ****************************************************************
// Turn-on and turn-off latency lookup
// ****************************************************************
module term_latency_lookup (
	input  wire       set_b,
	input  wire [2:0] band,
	output reg  [5:0] on_lat,
	output reg  [5:0] off_lat,
	output reg        band_ok
);

	// Bands below the supported range return zero and clear band_ok.
	always @* begin
		on_lat  = 6'h00;
		off_lat = 6'h00;
		band_ok = 1'b1;
		case ({set_b, band})
			4'h3: begin on_lat = `ON_A_B3; off_lat = `OFF_A_B3; end
			4'h4: begin on_lat = `ON_A_B3; off_lat = `OFF_A_B4; end
			4'h5: begin on_lat = `ON_A_B5; off_lat = `OFF_A_B5; end
			4'h6: begin on_lat = `ON_A_B5; off_lat = `OFF_A_B6; end
			4'h7: begin on_lat = `ON_A_B7; off_lat = `OFF_A_B7; end
			4'ha: begin on_lat = `ON_B_B2; off_lat = `OFF_B_B2; end
			4'hb: begin on_lat = `ON_B_B3; off_lat = `OFF_B_B3; end
			4'hc: begin on_lat = `ON_B_B4; off_lat = `OFF_B_B4; end
			4'hd: begin on_lat = `ON_B_B5; off_lat = `OFF_B_B5; end
			4'he: begin on_lat = `ON_B_B6; off_lat = `OFF_B_B6; end
			4'hf: begin on_lat = `ON_B_B7; off_lat = `OFF_B_B7; end
			default: band_ok = 1'b0;
		endcase
	end

endmodule // term_latency_lookup

`default_nettype wire

// File: src/dq_odt_control.v
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dq_odt_consts.vh"


module dq_odt_control (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire [`APB_ADDR_W-1:0] paddr,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [31:0]            pwdata,
	output reg                    pready,
	output reg  [31:0]            prdata,
	output reg                    pslverr,
	input  wire                   write1_cmd,
	input  wire                   cas2_cmd,
	input  wire                   power_down,
	input  wire                   self_refresh,
	output wire [`DQ_WIDTH-1:0]   dq_term_en,
	output reg                    dmi_term_en,
	output reg                    dqs_t_term_en,
	output reg                    dqs_c_term_en,
	output reg  [7:0]             termination_resistance,
	output reg                    term_settled
);

	// ****************************************************************
	// State encoding and window lengths
	// ****************************************************************
	localparam [4:0] ST_IDLE     = 5'h01;
	localparam [4:0] ST_WAIT_ON  = 5'h02;
	localparam [4:0] ST_RAMP_ON  = 5'h04;
	localparam [4:0] ST_ON       = 5'h08;
	localparam [4:0] ST_RAMP_OFF = 5'h10;

	// The switch window is far shorter than a pclk period, so each end is rounded
	// to whole cycles; a finer switch edge would need a faster clock.
	localparam [31:0]  WIN_MIN_I    = `WIN_MIN_CYC;
	localparam [31:0]  WIN_MAX_I    = `WIN_MAX_CYC;
	localparam [3:0]   WIN_MIN_LAST = WIN_MIN_I[3:0] - 4'h1;
	localparam [3:0]   WIN_MAX_LAST = WIN_MAX_I[3:0] - 4'h1;

	// ****************************************************************
	// Resistance decode
	// ****************************************************************

	// Nominal ohms of a setting code; used for the pins and for status.
	function [7:0] decode_ohms;
		input [2:0] code;
		begin
			case (code)
				3'h1:    decode_ohms = 8'hf0;
				3'h2:    decode_ohms = 8'h78;
				3'h3:    decode_ohms = 8'h50;
				3'h4:    decode_ohms = 8'h3c;
				3'h5:    decode_ohms = 8'h30;
				3'h6:    decode_ohms = 8'h28;
				default: decode_ohms = 8'h00;
			endcase
		end
	endfunction

	// ****************************************************************
	// Configuration register
	// ****************************************************************
	reg  [2:0] termination_setting_reg;
	reg        write_latency_set_b;
	reg  [2:0] freq_band;
	reg        burst32;
	reg        write_leveling;

	// Sequencer state.
	reg  [4:0] state;
	reg        armed;
	reg        lat_run;
	reg  [5:0] lat_count;
	reg  [3:0] ramp_count;
	reg        lane_switch;

	// Bus decode; a commit is the edge at which the master sees pready high.
	wire       apb_access = psel & penable;
	wire       apb_commit = apb_access & pready;
	wire       ctrl_hit   = (paddr == `REG_CTRL);
	wire       stat_hit   = (paddr == `REG_STATUS);

	// The reset word is split by field so that every field takes its value from one constant.
	localparam [31:0] RESET_WORD = `CTRL_RESET;

	// Software settings take effect on the edge that completes the write.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			termination_setting_reg <= RESET_WORD[`CTRL_SET_MSB:`CTRL_SET_LSB];
			write_latency_set_b     <= RESET_WORD[`CTRL_WRITE_LATENCY_SET_B];
			freq_band               <= RESET_WORD[`CTRL_BAND_MSB:`CTRL_BAND_LSB];
			burst32                 <= RESET_WORD[`CTRL_BL32];
			write_leveling          <= RESET_WORD[`CTRL_WR_LEVEL];
		end else if (apb_commit && pwrite && ctrl_hit) begin
			termination_setting_reg <= pwdata[`CTRL_SET_MSB:`CTRL_SET_LSB];
			write_latency_set_b     <= pwdata[`CTRL_WRITE_LATENCY_SET_B];
			freq_band               <= pwdata[`CTRL_BAND_MSB:`CTRL_BAND_LSB];
			burst32                 <= pwdata[`CTRL_BL32];
			write_leveling          <= pwdata[`CTRL_WR_LEVEL];
		end
	end

	// ****************************************************************
	// Latency selection
	// ****************************************************************
	wire [5:0] lut_on;
	wire [5:0] lut_off;
	wire       band_ok;

	// The table sits in its own module so that both latency sets are kept side by side.
	term_latency_lookup u_lookup (
		.set_b   (write_latency_set_b),
		.band    (freq_band),
		.on_lat  (lut_on),
		.off_lat (lut_off),
		.band_ok (band_ok)
	);

	// The table is read live, so a change of band mid-burst moves the end point.
	wire [5:0] term_on_latency  = lut_on;
	wire [5:0] term_off_latency = burst32 ? (lut_off + `BL32_EXTRA_CYC) : lut_off;

	// ****************************************************************
	// Qualification of commands
	// ****************************************************************
	wire term_enabled = (termination_setting_reg != `TERM_CODE_OFF);
	// Low power wins over a write in flight, since the lane receivers are off there.
	wire low_power    = power_down | self_refresh;
	// An unsupported band leaves the device unable to time the window at all.
	wire allowed      = term_enabled & band_ok & ~low_power;
	wire write_take   = write1_cmd & allowed;
	wire cas2_take    = cas2_cmd & armed & allowed;
	wire on_reached   = lat_run & (lat_count == term_on_latency);
	wire off_reached  = lat_run & (lat_count == term_off_latency) & ~cas2_take;

	// ****************************************************************
	// Termination sequencer
	// ****************************************************************

	// Leaving the allowed condition drops everything at once.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= ST_IDLE;
			armed      <= 1'b0;
			lat_run    <= 1'b0;
			lat_count  <= 6'h00;
			ramp_count <= 4'h0;
		end else if (!allowed) begin
			state      <= ST_IDLE;
			armed      <= 1'b0;
			lat_run    <= 1'b0;
			lat_count  <= 6'h00;
			ramp_count <= 4'h0;
		end else begin
			// A new write beats the consuming CAS-2 in the same cycle.
			if (write_take)
				armed <= 1'b1;
			else if (cas2_take)
				armed <= 1'b0;
			// The count restarts on every armed CAS-2, so back-to-back writes stretch the window.
			if (cas2_take) begin
				lat_count <= 6'h01;
				lat_run   <= 1'b1;
			end else if (lat_run) begin
				if (lat_count == term_off_latency)
					lat_run <= 1'b0;
				else
					lat_count <= lat_count + 6'h01;
			end
			// The ramp states stand for the analog switch window after each latency;
			// with this pclk each ramp lasts a single cycle.
			case (state)
				ST_IDLE: begin
					if (cas2_take)
						state <= ST_WAIT_ON;
				end
				ST_WAIT_ON: begin
					if (on_reached && !cas2_take) begin
						state      <= ST_RAMP_ON;
						ramp_count <= 4'h0;
					end
				end
				ST_RAMP_ON: begin
					if (ramp_count == WIN_MAX_LAST)
						state <= ST_ON;
					else
						ramp_count <= ramp_count + 4'h1;
				end
				ST_ON: begin
					if (off_reached) begin
						state      <= ST_RAMP_OFF;
						ramp_count <= 4'h0;
					end
				end
				ST_RAMP_OFF: begin
					if (ramp_count == WIN_MAX_LAST)
						// A CAS-2 that lands during the ramp re-enters the wait for its window.
						state <= (lat_run || cas2_take) ? ST_WAIT_ON : ST_IDLE;
					else
						ramp_count <= ramp_count + 4'h1;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Lane switch timing
	// ****************************************************************
	reg next_lane_switch;

	// The switch moves once the shortest window has passed inside a ramp.
	always @* begin
		next_lane_switch = lane_switch;
		if (!allowed)
			next_lane_switch = 1'b0;
		else if ((state == ST_RAMP_ON) && (ramp_count == WIN_MIN_LAST))
			next_lane_switch = 1'b1;
		else if ((state == ST_RAMP_OFF) && (ramp_count == WIN_MIN_LAST))
			next_lane_switch = 1'b0;
	end

	// One flop holds the switch; outside write leveling every lane enable copies its next value.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lane_switch <= 1'b0;
		else
			lane_switch <= next_lane_switch;
	end

	// ****************************************************************
	// Lane enables
	// ****************************************************************
	// Data and mask follow the sequencer and are held off in leveling; the strobes follow leveling while it is set.
	wire next_dq_on  = next_lane_switch & ~write_leveling;
	// Leveling needs the strobes loaded even without a write or a valid band.
	wire wl_strobe   = term_enabled & ~low_power;
	wire next_dqs_on = write_leveling ? wl_strobe : next_lane_switch;

	genvar gi;
	generate
		for (gi = 0; gi < `DQ_WIDTH; gi = gi + 1) begin : g_dq
			reg lane_q;
			// Each data pin gets its own flop so the enable fans out from the pad.
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					lane_q <= 1'b0;
				else
					lane_q <= next_dq_on;
			end
			assign dq_term_en[gi] = lane_q;
		end
	endgenerate

	// Mask, strobes, resistance and settled flag.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dmi_term_en            <= 1'b0;
			dqs_t_term_en          <= 1'b0;
			dqs_c_term_en          <= 1'b0;
			termination_resistance <= 8'h00;
			term_settled           <= 1'b0;
		end else begin
			dmi_term_en   <= next_dq_on;
			dqs_t_term_en <= next_dqs_on;
			dqs_c_term_en <= next_dqs_on;
			if (next_dq_on || next_dqs_on)
				termination_resistance <= decode_ohms(termination_setting_reg);
			else
				termination_resistance <= 8'h00;
			// Settled is withheld in write leveling, where the data lanes stay open.
			term_settled <= allowed & ~write_leveling
				& ((state == ST_RAMP_ON) && (ramp_count == WIN_MAX_LAST)
				|| (state == ST_ON) && !off_reached);
		end
	end

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// Unmapped offsets read zero and are refused by pslverr in the answer cycle.
	reg [31:0] rd_word;

	// Status exposes the sequencer so software can watch a window go by.
	always @* begin
		rd_word = 32'h0000_0000;
		if (ctrl_hit) begin
			rd_word[`CTRL_SET_MSB:`CTRL_SET_LSB]   = termination_setting_reg;
			rd_word[`CTRL_WRITE_LATENCY_SET_B]                = write_latency_set_b;
			rd_word[`CTRL_BAND_MSB:`CTRL_BAND_LSB] = freq_band;
			rd_word[`CTRL_BL32]                    = burst32;
			rd_word[`CTRL_WR_LEVEL]                = write_leveling;
		end else if (stat_hit) begin
			rd_word[4:0]   = state;
			rd_word[5]     = lane_switch;
			rd_word[6]     = armed;
			rd_word[7]     = band_ok;
			rd_word[15:8]  = decode_ohms(termination_setting_reg);
			rd_word[21:16] = term_on_latency;
			rd_word[29:24] = term_off_latency;
		end
	end

	// One wait state keeps prdata and pslverr straight from flops.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (apb_access && !pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr <= ~(ctrl_hit | stat_hit);
		end else begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

endmodule // dq_odt_control

`default_nettype wire

// File: tb/dq_odt_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dq_odt_consts.vh"
// ****************************************************************
// Port checker for lane termination
// ****************************************************************
module dq_odt_checker (
	input wire logic			pclk,
	input wire logic			presetn,
	input wire logic [`APB_ADDR_W-1:0]	paddr,
	input wire logic			psel,
	input wire logic			penable,
	input wire logic			pwrite,
	input wire logic [31:0]			pwdata,
	input wire logic			pready,
	input wire logic [31:0]			prdata,
	input wire logic			pslverr,
	input wire logic			write1_cmd,
	input wire logic			cas2_cmd,
	input wire logic			power_down,
	input wire logic			self_refresh,
	input wire logic [`DQ_WIDTH-1:0]	dq_term_en,
	input wire logic			dmi_term_en,
	input wire logic			dqs_t_term_en,
	input wire logic			dqs_c_term_en,
	input wire logic [7:0]			termination_resistance,
	input wire logic			term_settled
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [8:0]	ctrl;
	logic [5:0]	since_cas;
	// Shadow the control word and count edges since CAS-2; the count saturates so
	// that a switch left closed long after its window can never look recent.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= 9'h000;
			since_cas <= 6'h3f;
		end else begin
			if (psel && penable && pready && pwrite && paddr == `REG_CTRL)
				ctrl <= pwdata[8:0];
			if (cas2_cmd)
				since_cas <= 6'h01;
			else if (since_cas != 6'h3f)
				since_cas <= since_cas + 6'h01;
		end
	end
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_wl_on;
		ctrl[8] && ctrl[2:0] != 3'h0 && !power_down && !self_refresh;
	endsequence
	AST_APB_WAIT: assert property (s_access |=> pready ##1 !pready)
		else $error("apb answer not after one wait state");
	AST_APB_ERR: assert property (pready && paddr != `REG_CTRL && paddr != `REG_STATUS
		|-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
	AST_DISABLED: assert property (ctrl[2:0] == 3'h0 |=> !dqs_t_term_en && !dmi_term_en)
		else $error("lane terminated while disabled");
	AST_OHMS: assert property (dqs_t_term_en && $stable(ctrl)
		|-> termination_resistance * ctrl[2:0] == 12'h0f0) else $error("wrong ohms");
	AST_LOW_POWER: assert property ((power_down || self_refresh)
		|=> !dqs_t_term_en && !dmi_term_en) else $error("lane terminated in low power");
	AST_SETTLED: assert property (term_settled |-> dmi_term_en && dqs_t_term_en)
		else $error("settled without switches closed");
	AST_WINDOW: assert property (dmi_term_en |-> since_cas < 6'h36)
		else $error("termination held past the off latency");
	AST_RISE: assert property ($rose(dmi_term_en) |-> since_cas inside {[6:26]})
		else $error("termination rose outside the on latency range");
	AST_WL_DQS: assert property (s_wl_on ##1 s_wl_on |-> dqs_t_term_en)
		else $error("strobe not terminated in leveling");
	AST_WL_DQ: assert property (ctrl[8] |=> dq_term_en == 16'h0000)
		else $error("data lane terminated in leveling");
	AST_LANES: assert property (dq_term_en == {`DQ_WIDTH{dmi_term_en}})
		else $error("data and mask switches disagree");
	AST_STROBE: assert property (dqs_t_term_en == dqs_c_term_en)
		else $error("strobe pair switches disagree");
endmodule // dq_odt_checker

bind dq_odt_control dq_odt_checker i_dq_odt_checker (
	.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.write1_cmd(write1_cmd), .cas2_cmd(cas2_cmd), .power_down(power_down),
	.self_refresh(self_refresh), .dq_term_en(dq_term_en), .dmi_term_en(dmi_term_en),
	.dqs_t_term_en(dqs_t_term_en), .dqs_c_term_en(dqs_c_term_en),
	.termination_resistance(termination_resistance), .term_settled(term_settled)
);
`default_nettype wire

// File: tb/mem_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Memory controller issuing a write then its CAS-2
// ****************************************************************
module mem_ctrl_model (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire logic	go,
	input wire logic [1:0]	gap,
	output var logic	write1_cmd,
	output var logic	cas2_cmd,
	output var logic	busy
);
	logic [1:0]	cnt;
	// One write pulse, then CAS-2 after gap idle cycles, so both prompt and slow
	// controllers are seen; a new go is ignored until the pair is out.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write1_cmd <= 1'b0;
			cas2_cmd <= 1'b0;
			busy <= 1'b0;
			cnt <= 2'h0;
		end else begin
			write1_cmd <= go && !busy;
			cas2_cmd <= busy && cnt == 2'h0;
			if (go && !busy) begin
				busy <= 1'b1;
				cnt <= gap;
			end else if (busy) begin
				busy <= cnt != 2'h0;
				cnt <= cnt - 2'h1;
			end
		end
	end
endmodule // mem_ctrl_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dq_odt_consts.vh"
// ****************************************************************
// Testbench
// ****************************************************************
module tb_top;
	logic			pclk = 1'b0, presetn = 1'b0, go = 1'b0;
	logic [`APB_ADDR_W-1:0]	paddr = 12'h000;
	logic			psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0]		pwdata = 32'h0, prdata, seed = 32'h0000_003a;
	logic			pready, pslverr, write1_cmd, cas2_cmd, busy;
	logic			power_down = 1'b0, self_refresh = 1'b0;
	logic [`DQ_WIDTH-1:0]	dq_term_en;
	logic			dmi_term_en, dqs_t_term_en, dqs_c_term_en, term_settled;
	logic [7:0]		termination_resistance;
	logic [1:0]		gap = 2'h0;
	int			fail_count = 0, checks = 0, cyc = 0;
	int on_a[8] = '{0, 0, 0, 4, 4, 6, 6, 8};
	int on_b[8] = '{0, 0, 6, 12, 14, 18, 20, 24};
	int off_a[8] = '{0, 0, 0, 20, 22, 24, 26, 28};
	int off_b[8] = '{0, 0, 22, 28, 32, 36, 40, 44};

	dq_odt_control i_dq_odt_control (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.write1_cmd(write1_cmd), .cas2_cmd(cas2_cmd), .power_down(power_down),
		.self_refresh(self_refresh), .dq_term_en(dq_term_en), .dmi_term_en(dmi_term_en),
		.dqs_t_term_en(dqs_t_term_en), .dqs_c_term_en(dqs_c_term_en),
		.termination_resistance(termination_resistance), .term_settled(term_settled)
	);
	mem_ctrl_model i_mem_ctrl_model (
		.pclk(pclk), .presetn(presetn), .go(go), .gap(gap),
		.write1_cmd(write1_cmd), .cas2_cmd(cas2_cmd), .busy(busy)
	);

	// Free-running clock and a reset released on a rising edge.
	always #4 pclk = ~pclk;
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
	end
	// A hang costs a mismatch; the whole run needs well under this many cycles.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic conclude();
		if (fail_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// APB master: holds the request until pready is sampled high, then releases.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cfg(input logic [8:0] c);
		logic [31:0]	r;
		logic		e;
		apb(1'b1, `REG_CTRL, {23'h0, c}, r, e);
	endtask

	// One write and CAS-2; measures falling-edge counts to switch on and off.
	task automatic burst(input logic [1:0] g, input int eon, eoff, pd_at,
			input logic sr, input logic [7:0] ohm);
		int n, n_on, n_off;
		n_on = 0;
		n_off = 0;
		@(posedge pclk);
		go <= 1'b1;
		gap <= g;
		@(posedge pclk);
		go <= 1'b0;
		for (n = 0; n < 9 && cas2_cmd !== 1'b1; n++) @(negedge pclk);
		for (n = 1; n < 64; n++) begin
			// Low power is raised on a rising edge; the lanes are looked at on the falling one.
			@(posedge pclk);
			if (n == pd_at && sr)
				self_refresh <= 1'b1;
			else if (n == pd_at)
				power_down <= 1'b1;
			@(negedge pclk);
			if (dmi_term_en === 1'b1 && n_on == 0) begin
				n_on = n;
				chk({dq_term_en, dqs_t_term_en, dqs_c_term_en, term_settled,
					termination_resistance}, {16'hffff, 3'h7, ohm});
			end
			if (dmi_term_en !== 1'b1 && n_on != 0 && n_off == 0)
				n_off = n;
		end
		@(posedge pclk);
		power_down <= 1'b0;
		self_refresh <= 1'b0;
		chk(n_on, eon);
		chk(n_off, eoff);
	endtask

	initial begin
		logic [31:0]	r, x;
		logic		e, sb, bl;
		logic [2:0]	bd, s;
		int		i, nn, m;
		@(posedge presetn);
		apb(1'b0, `REG_CTRL, 32'h0, r, e);
		chk({e, r}, 40'h0);
		apb(1'b1, 12'h00c, 32'hffff_ffff, r, e);
		chk(e, 40'h1);
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk({e, r}, {8'h01, 32'h0});
		apb(1'b1, `REG_STATUS, 32'hffff_ffff, r, e);
		chk({e, r}, 40'h0);
		apb(1'b0, `REG_CTRL, 32'h0, r, e);
		chk(r, 40'h0);
		cfg(9'h030);
		burst(2'h0, 0, 0, 0, 1'b0, 8'h00);
		cfg(9'h022);
		burst(2'h1, 0, 0, 0, 1'b0, 8'h00);
		cfg(9'h01a);
		burst(2'h2, 0, 0, 0, 1'b0, 8'h00);
		cfg(9'h031);
		for (i = 0; i < 2; i++) burst(2'h0, 6, 11, 10, i[0], 8'hf0);
		cfg(9'h133);
		repeat (3) @(posedge pclk);
		chk({dq_term_en, dmi_term_en, dqs_t_term_en, dqs_c_term_en}, 40'h3);
		burst(2'h0, 0, 0, 0, 1'b0, 8'h00);
		cfg(9'h130);
		repeat (3) @(posedge pclk);
		chk({dqs_t_term_en, dqs_c_term_en}, 40'h0);
		for (i = 0; i < 24; i++) begin
			x = xs();
			sb = x[0];
			bd = sb ? 3'h2 + x[3:1] % 3'h6 : 3'h3 + x[3:1] % 3'h5;
			bl = x[4];
			s = 3'h1 + x[7:5] % 3'h6;
			nn = sb ? on_b[bd] : on_a[bd];
			m = (sb ? off_b[bd] : off_a[bd]) + (bl ? 8 : 0);
			cfg({1'b0, bl, bd, sb, s});
			apb(1'b0, `REG_STATUS, 32'h0, r, e);
			chk({r[29:24], r[21:7], r[4:0]}, {m[5:0], nn[5:0], 8'(240 / s), 6'h21});
			burst(x[9:8], nn + 2, m + 2, 0, 1'b0, 8'(240 / s));
		end
		conclude();
	end
endmodule // tb_top
`default_nettype wire
